// ---- hw/serial_eeprom_controller.sv ----
`timescale 1ns/100ps
`default_nettype none
module serial_eeprom_controller
  import eeprom_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = TIMEOUT_CYC,
  parameter int HALF_CYCLES = SCLK_HALF_CYC
) (
  input wire logic clk, // Core clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic soft_rst, // Soft reset pulse, restarts address load.
  input wire cmd_req_t cmd_in, // Command code and target location.
  input wire logic cmd_start, // Write of one to the busy flag.
  input wire logic data_wr, // Write strobe for the data register.
  input wire logic [7:0] data_wdata, // Data register write value.
  input wire logic addr_wr, // Software write of station address.
  input wire logic [47:0] addr_wdata, // Station address from software.
  input wire logic if_enable, // Serial interface enable.
  input wire logic mon_sel, // Disabled pins show monitor signals.
  input wire logic gp_data_out, // General-purpose level, data pin.
  input wire logic gp_data_oe, // General-purpose enable, data pin.
  input wire logic gp_clk_out, // General-purpose level, clock pin.
  input wire logic [1:0] mii_mon, // Monitor signals: [1] data, [0] clock.
  input wire logic sdio_in, // Serial data pin, input side.
  output logic sdio_out, // Serial data pin, output side.
  output logic sdio_oe, // Serial data pin, output enable.
  output logic serial_clock_out, // Serial clock pin.
  output logic select_out, // Memory chip select.
  output logic busy, // Operation busy flag.
  output logic timeout, // Response timeout flag.
  output logic addr_loaded, // Station address loaded.
  output logic [7:0] data, // Data register contents.
  output logic [47:0] station_addr // Station address.
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ctl_state_t st_ff;
  cmd_code_t op_ff;
  logic [LOC_W-1:0] loc_ff;
  logic [7:0] data_ff;
  logic [7:0] rd_ff;
  logic [FRAME_W-1:0] sh_ff;
  logic [4:0] bit_ff;
  logic [HALF_W-1:0] half_ff;
  logic [TIMEOUT_W-1:0] to_ff;
  logic sclk_ff, cs_ff, pend_ff, boot_ff;
  logic busy_ff, timeout_ff, loaded_ff;
  logic [47:0] station_ff;
  logic din_s1_ff, din_s2_ff;
  logic pin_clk_ff, pin_dat_ff, pin_oe_ff, pin_cs_ff;

  // ----------------------------------------------------------------
  // Frame build
  // ----------------------------------------------------------------
  logic [FRAME_W-1:0] frame;
  logic long_frame, timed;

  // Every frame is left aligned in an 18-bit shifter; short frames
  // simply stop after ten clocks.
  always_comb begin
    frame = {1'b1, OPC_EXT, EXT_LOCK, 5'h00, 8'h00};
    long_frame = 1'b0;
    timed = 1'b0;
    case (op_ff)
      CMD_FETCH_ONE, CMD_RELOAD: begin
        frame = {1'b1, OPC_READ, loc_ff, 8'h00};
        long_frame = 1'b1;
      end
      CMD_STORE_ONE: begin
        frame = {1'b1, OPC_WRITE, loc_ff, data_ff};
        long_frame = 1'b1;
        timed = 1'b1;
      end
      CMD_STORE_EVERY: begin
        frame = {1'b1, OPC_EXT, EXT_STORE_ALL, 5'h00, data_ff};
        long_frame = 1'b1;
        timed = 1'b1;
      end
      CMD_CLEAR_ONE: begin
        frame = {1'b1, OPC_ERASE, loc_ff, 8'h00};
        timed = 1'b1;
      end
      CMD_CLEAR_EVERY: begin
        frame = {1'b1, OPC_EXT, EXT_CLR_ALL, 5'h00, 8'h00};
        timed = 1'b1;
      end
      CMD_UNLOCK: frame = {1'b1, OPC_EXT, EXT_UNLOCK, 5'h00, 8'h00};
      default: frame = {1'b1, OPC_EXT, EXT_LOCK, 5'h00, 8'h00};
    endcase
  end

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire host_go = cmd_start & ~busy_ff;
  wire launch = boot_ff | pend_ff | host_go;
  wire tick = (half_ff == HALF_W'(HALF_CYCLES - 1));
  wire fall = (st_ff == ST_SHIFT) & tick & sclk_ff;
  wire [4:0] frame_len = long_frame ? LEN_LONG : LEN_SHORT;
  wire last_bit = (bit_ff == frame_len - 5'h01);
  wire in_data = (bit_ff >= HDR_BITS);
  wire is_read = (op_ff == CMD_FETCH_ONE) | (op_ff == CMD_RELOAD);
  wire settled = (to_ff >= TIMEOUT_W'(HALF_CYCLES));
  wire ready = (st_ff == ST_POLL) & settled & din_s2_ff;
  wire expired = (st_ff == ST_POLL) & ~ready &
                 (to_ff == TIMEOUT_W'(TIMEOUT_CYCLES - 1));
  wire fin = ((st_ff == ST_GAP) & tick & ~timed) | ready | expired;
  wire reload = (op_ff == CMD_RELOAD);
  wire sig_ok = (rd_ff == SIGNATURE);
  wire at_sig = (loc_ff == SIG_LOC);
  wire at_last = (loc_ff == LAST_ADDR_LOC);
  wire more = reload & ~expired & (at_sig ? sig_ok : ~at_last);
  wire [2:0] byte_idx = 3'(loc_ff - 7'h01);
  wire eep_oe = (st_ff == ST_SHIFT) & ~(is_read & in_data);

  // ----------------------------------------------------------------
  // Input synchroniser
  // ----------------------------------------------------------------
  // The data pin comes from outside; only the second stage is read.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      din_s1_ff <= 1'b0;
      din_s2_ff <= 1'b0;
    end else begin
      din_s1_ff <= sdio_in;
      din_s2_ff <= din_s1_ff;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // A soft reset aborts anything in flight and reruns the address load.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= ST_IDLE;
      cs_ff <= 1'b0;
      sclk_ff <= 1'b0;
    end else if (soft_rst) begin
      st_ff <= ST_IDLE;
      cs_ff <= 1'b0;
      sclk_ff <= 1'b0;
    end else begin
      case (st_ff)
        ST_IDLE: if (launch) st_ff <= ST_START;
        ST_START: begin
          st_ff <= ST_SHIFT;
          cs_ff <= 1'b1;
        end
        ST_SHIFT: if (tick) begin
          sclk_ff <= ~sclk_ff;
          if (sclk_ff && last_bit) begin
            st_ff <= ST_GAP;
            cs_ff <= 1'b0;
          end
        end
        ST_GAP: if (tick) begin
          // Raising select again makes the memory show its ready level.
          st_ff <= timed ? ST_POLL : ST_IDLE;
          cs_ff <= timed;
        end
        ST_POLL: if (fin) begin
          st_ff <= ST_IDLE;
          cs_ff <= 1'b0;
        end
        default: st_ff <= ST_IDLE;
      endcase
    end
  end

  // Half period counter for the generated serial clock.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) half_ff <= '0;
    else if (st_ff == ST_IDLE || st_ff == ST_START || tick) half_ff <= '0;
    else half_ff <= half_ff + HALF_W'(1);
  end

  // Shifter: a new bit leaves on each falling serial clock edge, and
  // read data is sampled there too, half a period after it changed.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sh_ff <= '0;
      bit_ff <= '0;
      rd_ff <= '0;
    end else if (st_ff == ST_START) begin
      sh_ff <= frame;
      bit_ff <= '0;
    end else if (fall) begin
      sh_ff <= {sh_ff[FRAME_W-2:0], 1'b0};
      bit_ff <= bit_ff + 5'h01;
      if (in_data) rd_ff <= {rd_ff[6:0], din_s2_ff};
    end
  end

  // Timeout counter runs only while the memory is self-timing, so slow
  // serial clocks never eat into the 30 ms budget.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) to_ff <= '0;
    else if (st_ff != ST_POLL) to_ff <= '0;
    else to_ff <= to_ff + TIMEOUT_W'(1);
  end

  // ----------------------------------------------------------------
  // Command and status
  // ----------------------------------------------------------------
  // Busy and boot start set so that the host sees a busy controller
  // until the post-reset load attempt ends.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_ff <= 1'b1;
      boot_ff <= 1'b1;
      pend_ff <= 1'b0;
      op_ff <= CMD_RELOAD;
      loc_ff <= SIG_LOC;
    end else if (soft_rst) begin
      busy_ff <= 1'b1;
      boot_ff <= 1'b1;
      pend_ff <= 1'b0;
    end else if (st_ff == ST_IDLE && launch) begin
      busy_ff <= 1'b1;
      boot_ff <= 1'b0;
      pend_ff <= 1'b0;
      if (boot_ff) begin
        op_ff <= CMD_RELOAD;
        loc_ff <= SIG_LOC;
      end else if (!pend_ff) begin
        op_ff <= cmd_in.code;
        loc_ff <= (cmd_in.code == CMD_RELOAD) ? SIG_LOC : cmd_in.loc;
      end
    end else if (fin) begin
      pend_ff <= more;
      busy_ff <= more;
      if (more) loc_ff <= loc_ff + 7'h01;
    end
  end

  // Flags: a new command clears the timeout flag; the load flag clears
  // when a reload starts and sets only on a complete address.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timeout_ff <= 1'b0;
      loaded_ff <= 1'b0;
    end else if (soft_rst) begin
      loaded_ff <= 1'b0;
    end else if (st_ff == ST_IDLE && launch && !pend_ff) begin
      timeout_ff <= 1'b0;
      if (boot_ff || cmd_in.code == CMD_RELOAD) loaded_ff <= 1'b0;
    end else if (fin) begin
      if (expired) timeout_ff <= 1'b1;
      if (reload && at_last && !at_sig) loaded_ff <= 1'b1;
    end
  end

  // Data register: host writes it while idle, a fetch overwrites it.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) data_ff <= 8'h00;
    else if (fin && op_ff == CMD_FETCH_ONE) data_ff <= rd_ff;
    else if (data_wr && !busy_ff) data_ff <= data_wdata;
  end

  // Station address: byte n comes from location n plus one. Without a
  // signature nothing is written, so a software value survives.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) station_ff <= 48'h0000_0000_0000;
    else if (fin && reload && !at_sig)
      station_ff[8*byte_idx +: 8] <= rd_ff;
    else if (addr_wr) station_ff <= addr_wdata;
  end

  // ----------------------------------------------------------------
  // Pin multiplexing
  // ----------------------------------------------------------------
  // With the interface off the pins serve as plain outputs or monitors;
  // the engine keeps running unseen, so the host should stay idle.
  wire nxt_pin_clk = if_enable ? sclk_ff :
                     (mon_sel ? mii_mon[0] : gp_clk_out);
  wire nxt_pin_dat = if_enable ? sh_ff[FRAME_W-1] :
                     (mon_sel ? mii_mon[1] : gp_data_out);
  wire nxt_pin_oe = if_enable ? eep_oe : (mon_sel | gp_data_oe);
  wire nxt_pin_cs = if_enable & cs_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_clk_ff <= 1'b0;
      pin_dat_ff <= 1'b0;
      pin_oe_ff <= 1'b0;
      pin_cs_ff <= 1'b0;
    end else begin
      pin_clk_ff <= nxt_pin_clk;
      pin_dat_ff <= nxt_pin_dat;
      pin_oe_ff <= nxt_pin_oe;
      pin_cs_ff <= nxt_pin_cs;
    end
  end

  assign serial_clock_out = pin_clk_ff;
  assign sdio_out = pin_dat_ff;
  assign sdio_oe = pin_oe_ff;
  assign select_out = pin_cs_ff;
  assign busy = busy_ff;
  assign timeout = timeout_ff;
  assign addr_loaded = loaded_ff;
  assign data = data_ff;
  assign station_addr = station_ff;

endmodule : serial_eeprom_controller
`default_nettype wire

// ---- hw/eeprom_pkg.sv ----
package eeprom_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int TIMEOUT_MS = 30;
  localparam int TIMEOUT_CYC = TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int TIMEOUT_W = 23;
  localparam int SCLK_HALF_NS = 500;
  localparam int SCLK_HALF_CYC =
    (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HALF_W = 16;

  // ----------------------------------------------------------------
  // Serial frame layout
  // ----------------------------------------------------------------
  localparam int LOC_W = 7;
  localparam int FRAME_W = 18;
  localparam logic [4:0] LEN_SHORT = 5'h0A;
  localparam logic [4:0] LEN_LONG = 5'h12;
  localparam logic [4:0] HDR_BITS = 5'h0A;
  localparam logic [1:0] OPC_EXT = 2'h0;
  localparam logic [1:0] OPC_WRITE = 2'h1;
  localparam logic [1:0] OPC_READ = 2'h2;
  localparam logic [1:0] OPC_ERASE = 2'h3;
  localparam logic [1:0] EXT_LOCK = 2'h0;
  localparam logic [1:0] EXT_STORE_ALL = 2'h1;
  localparam logic [1:0] EXT_CLR_ALL = 2'h2;
  localparam logic [1:0] EXT_UNLOCK = 2'h3;

  // ----------------------------------------------------------------
  // Address load
  // ----------------------------------------------------------------
  localparam logic [7:0] SIGNATURE = 8'hA5;
  localparam logic [6:0] SIG_LOC = 7'h00;
  localparam logic [6:0] LAST_ADDR_LOC = 7'h06;

  typedef enum logic [2:0] {
    CMD_FETCH_ONE = 3'h0,
    CMD_LOCK = 3'h1,
    CMD_UNLOCK = 3'h2,
    CMD_STORE_ONE = 3'h3,
    CMD_STORE_EVERY = 3'h4,
    CMD_CLEAR_ONE = 3'h5,
    CMD_CLEAR_EVERY = 3'h6,
    CMD_RELOAD = 3'h7
  } cmd_code_t;

  typedef struct packed {
    cmd_code_t code;
    logic [LOC_W-1:0] loc;
  } cmd_req_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_SHIFT, ST_GAP, ST_POLL
  } ctl_state_t;

endpackage : eeprom_pkg

// ---- verification/eeprom_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module eeprom_model (
  input wire logic clk, // Core clock, used to find edges.
  input wire logic sclk, // Serial clock from the controller.
  input wire logic cs, // Chip select, active high.
  input wire logic di, // Resolved data line level.
  input wire logic mute, // When set, never reports ready.
  output logic do_o, // Data driven by the memory.
  output logic do_oe // High while the memory drives the line.
);
  // ----------------------------------------------------------------
  // Behavioural memory
  // ----------------------------------------------------------------
  logic [7:0] mem [128];
  logic [17:0] sh = 18'h00000;
  logic [9:0] hdr = 10'h000;
  logic [4:0] n = 5'h00;
  logic sck_q = 1'b0;
  logic cs_q = 1'b0;
  logic wen = 1'b0;
  logic pend = 1'b0;
  int busy_n = 0;
  wire [1:0] op = hdr[8:7];
  wire timed = op[0] | ((op == 2'h0) & (hdr[6] ^ hdr[5]));
  // Bits shift in on serial rising edges; cells change as select falls.
  // The poll answer is driven only after a timed frame, so the start
  // bit of the next frame never meets a second driver.
  always @(posedge clk) begin
    sck_q <= sclk;
    cs_q <= cs;
    if (busy_n != 0) busy_n <= busy_n - 1;
    if (cs && sclk && !sck_q) begin
      n <= n + 5'h01;
      sh <= {sh[16:0], di};
      if (n == 5'h09) hdr <= {sh[8:0], di};
      if (n >= 5'h0A && op == 2'h2) begin
        do_oe <= 1'b1;
        do_o <= mem[hdr[6:0]][5'h11 - n];
      end
    end
    if (cs && n == 5'h00 && pend) begin
      do_oe <= 1'b1;
      do_o <= (busy_n == 0) && !mute;
    end
    if (!cs) begin
      n <= 5'h00;
      do_oe <= 1'b0;
    end
    if (cs_q && !cs) begin
      pend <= (n != 5'h00) && timed;
      busy_n <= wen ? 20 : 0;
      if (n == 5'h0A && op == 2'h0 && hdr[6:5] != 2'h2)
        wen <= hdr[5];
      for (int i = 0; i < 128; i++) begin
        if (wen && timed && n != 5'h00 && (op == 2'h0 || i == hdr[6:0]))
          mem[i] <= (op[1] | (~op[0] & hdr[6])) ? 8'hFF : sh[7:0];
      end
    end
  end
endmodule : eeprom_model
`default_nettype wire

// ---- verification/serial_eeprom_controller_asserts.sv ----
`timescale 1ns/100ps
`default_nettype none
module serial_eeprom_controller_asserts import eeprom_pkg::*; #(
  parameter int TIMEOUT_CYCLES = TIMEOUT_CYC,
  parameter int HALF_CYCLES = SCLK_HALF_CYC
) (
  input wire logic clk, // Core clock.
  input wire logic rst, // Asynchronous reset.
  input wire logic soft_rst, // Soft reset pulse.
  input wire logic cmd_start, // Command start.
  input wire logic data_wr, // Data register write.
  input wire logic [7:0] data_wdata, // Data write value.
  input wire logic if_enable, // Interface enable.
  input wire logic mon_sel, // Monitor select.
  input wire logic gp_data_out, // Level for data pin.
  input wire logic gp_data_oe, // Enable for data pin.
  input wire logic gp_clk_out, // Level for clock pin.
  input wire logic [1:0] mii_mon, // Monitor signals.
  input wire logic sdio_out, // Data pin out.
  input wire logic sdio_oe, // Data pin enable.
  input wire logic serial_clock_out, // Clock pin.
  input wire logic select_out, // Chip select.
  input wire logic busy, // Busy flag.
  input wire logic timeout, // Timeout flag.
  input wire logic addr_loaded, // Address loaded.
  input wire logic [7:0] data // Data register.
);
  // ----------------------------------------------------------------
  // Serial clock counter
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [4:0] nclk_ff;
  logic sck_ff;
  logic [4:0] nxt_nclk;
  assign nxt_nclk = !select_out ? 5'h00 :
    nclk_ff + {4'h0, serial_clock_out & ~sck_ff};
  // Rising edges are counted only inside a frame.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      nclk_ff <= 5'h00;
      sck_ff <= 1'b0;
    end else begin
      nclk_ff <= nxt_nclk;
      sck_ff <= serial_clock_out;
    end
  end
  AST_START_BUSY: assert property (cmd_start && !busy && !soft_rst
    |=> busy) else $error("busy not raised");
  AST_FRAME_START: assert property (cmd_start && !busy && !soft_rst
    && if_enable ##1 if_enable [*2] |=> select_out && sdio_oe && sdio_out)
    else $error("frame did not open with start bit");
  // A soft reset drops select two edges later, so its cut frame is excused.
  AST_CLK_COUNT: assert property ($fell(select_out) && if_enable
    && !$past(soft_rst, 2) |-> nclk_ff == 5'h0A || nclk_ff == 5'h12 ||
    nclk_ff == 5'h00) else $error("wrong serial clock count");
  // The boot load after a soft reset is a new command and clears the flag.
  AST_TO_STICKY: assert property (timeout && !(cmd_start && !busy)
    && !soft_rst && !$past(soft_rst) |=> timeout)
    else $error("timeout flag dropped");
  AST_TO_AT_END: assert property ($rose(timeout) |-> $fell(busy))
    else $error("timeout without completion");
  AST_LOADED_AT_END: assert property ($rose(addr_loaded)
    |-> $fell(busy)) else $error("address loaded off completion");
  AST_DATA_WRITE: assert property (!busy && data_wr && !cmd_start
    && !soft_rst |=> data == $past(data_wdata)) else $error("data lost");
  AST_PINS_MON: assert property (!if_enable && mon_sel |=>
    serial_clock_out == $past(mii_mon[0]) && sdio_out == $past(mii_mon[1])
    && !select_out) else $error("monitor pins wrong");
  AST_PINS_GP: assert property (!if_enable && !mon_sel |=>
    sdio_out == $past(gp_data_out) && sdio_oe == $past(gp_data_oe) &&
    serial_clock_out == $past(gp_clk_out)) else $error("gp pins wrong");
  AST_SOFT_BUSY: assert property (soft_rst |=> busy)
    else $error("soft reset left busy low");
  AST_CLK_IDLE: assert property ($past(if_enable) && !select_out
    |-> !serial_clock_out) else $error("serial clock moved outside frame");
  AST_TO_IN_POLL: assert property ($rose(timeout)
    |-> select_out && !serial_clock_out) else $error("timeout outside poll");
endmodule : serial_eeprom_controller_asserts
bind serial_eeprom_controller serial_eeprom_controller_asserts #(
  .TIMEOUT_CYCLES(TIMEOUT_CYCLES), .HALF_CYCLES(HALF_CYCLES)
) serial_eeprom_controller_asserts_inst (.clk, .rst, .soft_rst, .cmd_start,
  .data_wr, .data_wdata, .if_enable, .mon_sel, .gp_data_out, .gp_data_oe,
  .gp_clk_out, .mii_mon, .sdio_out, .sdio_oe, .serial_clock_out,
  .select_out, .busy, .timeout, .addr_loaded, .data);
`default_nettype wire

// ---- verification/serial_eeprom_controller_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module serial_eeprom_controller_tb_top import eeprom_pkg::*; ;
  // ----------------------------------------------------------------
  // Bench signals and instances
  // ----------------------------------------------------------------
  logic clk, rst, soft_rst, cmd_start, data_wr, addr_wr, if_enable, mon_sel;
  logic gp_data_out, gp_data_oe, gp_clk_out, sdio_in, mute, do_o, do_oe;
  logic sdio_out, sdio_oe, serial_clock_out, select_out, busy, timeout;
  logic addr_loaded;
  logic tog = 1'b0;
  cmd_req_t cmd_in;
  logic [7:0] data_wdata, data;
  logic [47:0] addr_wdata, station_addr;
  logic [1:0] mii_mon;
  int num_errors = 0;
  int compares = 0;
  // A released line shows a changing level, never the last bit.
  assign sdio_in = sdio_oe ? sdio_out : (do_oe ? do_o : tog);
  always @(posedge clk) tog <= ~tog;
  serial_eeprom_controller #(.TIMEOUT_CYCLES(400), .HALF_CYCLES(10))
    serial_eeprom_controller_inst (.clk, .rst, .soft_rst, .cmd_in,
    .cmd_start, .data_wr, .data_wdata, .addr_wr, .addr_wdata, .if_enable,
    .mon_sel, .gp_data_out, .gp_data_oe, .gp_clk_out, .mii_mon, .sdio_in,
    .sdio_out, .sdio_oe, .serial_clock_out, .select_out, .busy, .timeout,
    .addr_loaded, .data, .station_addr);
  eeprom_model eeprom_model_inst (.clk, .sclk(serial_clock_out),
    .cs(select_out), .di(sdio_in), .mute, .do_o, .do_oe);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Closing report, also reached when a wait runs out.
  task automatic stop_test();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [47:0] got, exp, input string m);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s got %h", $time, m, got);
    end
  endtask : chk
  task automatic wait_idle();
    for (int i = 0; i < 4000; i++) begin
      @(posedge clk);
      #1;
      if (busy === 1'b0) return;
    end
    chk(busy, 48'h0, "busy stuck");
    stop_test();
  endtask : wait_idle
  // Data goes in first, the command one edge later.
  task automatic cmd(input cmd_code_t c, input logic [6:0] a, logic [7:0] d);
    @(posedge clk);
    #1 data_wdata = d;
    data_wr = 1'b1;
    @(posedge clk);
    #1 data_wr = 1'b0;
    cmd_in = '{code: c, loc: a};
    cmd_start = 1'b1;
    @(posedge clk);
    #1 cmd_start = 1'b0;
    wait_idle();
  endtask : cmd
  // The seed byte differs from the answer, so a stale register shows.
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    cmd(CMD_FETCH_ONE, a, ~e);
    chk(data, e, "fetch");
  endtask : rd
  task automatic set_addr(input logic [47:0] v);
    @(posedge clk);
    #1 addr_wdata = v;
    addr_wr = 1'b1;
    @(posedge clk);
    #1 addr_wr = 1'b0;
  endtask : set_addr
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_rw();
    rd(7'h7F, 8'h5A);
    cmd(CMD_STORE_ONE, 7'h0A, 8'hC3);
    rd(7'h0A, 8'h00);
    cmd(CMD_UNLOCK, 7'h00, 8'h00);
    cmd(CMD_STORE_ONE, 7'h0A, 8'hC3);
    rd(7'h0A, 8'hC3);
    cmd(CMD_CLEAR_ONE, 7'h0A, 8'h00);
    rd(7'h0A, 8'hFF);
    cmd(CMD_STORE_EVERY, 7'h00, 8'h3C);
    chk(timeout, 48'h0, "no timeout");
    rd(7'h33, 8'h3C);
    cmd(CMD_CLEAR_EVERY, 7'h00, 8'h00);
    rd(7'h00, 8'hFF);
    $display("test read write done");
  endtask : t_rw
  task automatic t_reload();
    set_addr(48'h0123456789AB);
    cmd(CMD_RELOAD, 7'h00, 8'h00);
    chk(addr_loaded, 48'h0, "reload fail");
    chk(station_addr, 48'h0123456789AB, "address kept");
    cmd(CMD_STORE_ONE, 7'h00, 8'hA5);
    cmd(CMD_STORE_ONE, 7'h01, 8'h77);
    cmd(CMD_RELOAD, 7'h00, 8'h00);
    chk(addr_loaded, 48'h1, "reload ok");
    chk(station_addr, 48'hFFFFFFFFFF77, "reload address");
    cmd(CMD_LOCK, 7'h00, 8'h00);
    cmd(CMD_STORE_ONE, 7'h01, 8'h12);
    rd(7'h01, 8'h77);
    $display("test reload done");
  endtask : t_reload
  task automatic t_timeout();
    mute = 1'b1;
    cmd(CMD_CLEAR_ONE, 7'h02, 8'h00);
    chk(timeout, 48'h1, "timeout set");
    mute = 1'b0;
    rd(7'h02, 8'hFF);
    chk(timeout, 48'h0, "timeout cleared");
    $display("test timeout done");
  endtask : t_timeout
  task automatic t_pins();
    if_enable = 1'b0;
    mon_sel = 1'b1;
    mii_mon = 2'h2;
    @(posedge clk);
    #1 chk({select_out, serial_clock_out, sdio_out}, 48'h1, "mon");
    mon_sel = 1'b0;
    @(posedge clk);
    #1 chk({serial_clock_out, sdio_out, sdio_oe}, 48'h5, "gp");
    if_enable = 1'b1;
    $display("test pins done");
  endtask : t_pins
  task automatic t_soft();
    set_addr(48'h0000000000AB);
    soft_rst = 1'b1;
    @(posedge clk);
    #1 soft_rst = 1'b0;
    chk(busy, 48'h1, "soft busy");
    wait_idle();
    chk(addr_loaded, 48'h1, "soft load");
    chk(station_addr, 48'hFFFFFFFFFF77, "soft address");
    $display("test soft reset done");
  endtask : t_soft
  // Main sequence: boot load first, host traffic only after it.
  initial begin
    {rst, if_enable, gp_clk_out, gp_data_oe} = 4'hF;
    {soft_rst, cmd_start, data_wr, addr_wr, mon_sel, gp_data_out} = 6'h00;
    {mute, mii_mon, data_wdata, addr_wdata} = '0;
    cmd_in = '{code: CMD_FETCH_ONE, loc: 7'h00};
    for (int i = 0; i < 128; i++) eeprom_model_inst.mem[i] = 8'h00;
    for (int i = 1; i < 7; i++) eeprom_model_inst.mem[i] = 8'(i * 17);
    eeprom_model_inst.mem[0] = 8'hA5;
    eeprom_model_inst.mem[127] = 8'h5A;
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    wait_idle();
    chk(addr_loaded, 48'h1, "boot loaded");
    chk(station_addr, 48'h665544332211, "boot address");
    t_rw();
    t_reload();
    t_timeout();
    t_pins();
    t_soft();
    stop_test();
  end
endmodule : serial_eeprom_controller_tb_top
`default_nettype wire
